/* File: common/dac_enable_pkg.sv */
// package: register map, field positions and types for the converter enable block
package dac_enable_pkg;
  // register index as printed; the byte address is four times this
  localparam logic [19:0] dac_control_index = 20'hFFF9E;
  localparam logic [21:0] dac_control_addr = {dac_control_index, 2'b00};
  localparam int ch1_oe_bit = 7;
  localparam int ch0_oe_bit = 6;
  localparam int shared_en_bit = 5;
  localparam logic [2:0] enables_reset = 3'h0;
  localparam logic [4:0] unused_read = 5'h1F;
  localparam logic [7:0] reg_write_mask = 8'hE0;

  typedef struct packed {
    logic ch1_output_enable;
    logic ch0_output_enable;
    logic shared_conversion_enable;
  } dac_control_t;

  typedef struct packed {
    logic conv_en_ch0;
    logic conv_en_ch1;
    logic analog_out_ch0;
    logic analog_out_ch1;
  } dac_enables_t;
endpackage

/* File: core/dac_enable_control.sv */
// design: converter enable control register with a wishbone slave port
//
// Overview of operation
// - with both output enables clear, both channels stay off regardless of shared bit
// - only channel-0 enable set, shared clear: channel 0 converts, channel 1 off
// - only channel-1 enable set, shared clear: channel 1 converts, channel 0 off
// - both enables set, or one set with shared bit set: both channels convert
// - channel-0 enable drives channel-0 conversion and its analog output
// - channel-1 enable drives channel-1 conversion and its analog output
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dac_enable_control #(
  parameter int addr_width = 24
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [addr_width-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic conv_en_ch0,
  output logic conv_en_ch1,
  output logic analog_out_ch0,
  output logic analog_out_ch1
);
  initial begin
    if (addr_width < 22 || addr_width > 32) begin
      $error("addr_width must cover the register address");
    end
  end

  logic rst_meta_reg;
  logic rst_sync_n_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  function automatic dac_enable_pkg::dac_enables_t decode_enables(
    input dac_enable_pkg::dac_control_t c);
    dac_enable_pkg::dac_enables_t e;
    logic any_oe;
    any_oe = c.ch0_output_enable | c.ch1_output_enable;
    // either enable plus shared bit turns on both converters
    e.conv_en_ch0 = c.ch0_output_enable |
                    (any_oe & c.shared_conversion_enable);
    e.conv_en_ch1 = c.ch1_output_enable |
                    (any_oe & c.shared_conversion_enable);
    e.analog_out_ch0 = c.ch0_output_enable;
    e.analog_out_ch1 = c.ch1_output_enable;
    return e;
  endfunction

  dac_enable_pkg::dac_control_t ctrl_reg;
  dac_enable_pkg::dac_control_t ctrl_next;
  dac_enable_pkg::dac_enables_t en_reg;
  dac_enable_pkg::dac_enables_t en_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic hit;
  logic req;

  always_comb begin
    req = wb_cyc_i & wb_stb_i & ~ack_reg;
    hit = wb_adr_i[21:2] == dac_enable_pkg::dac_control_index;
    ctrl_next = ctrl_reg;
    ack_next = req;
    dat_next = 32'h0000_0000;
    if (req && hit && wb_we_i && wb_sel_i[0]) begin
      // low bits of the write are dropped by taking only bits 7:5
      ctrl_next = dac_enable_pkg::dac_control_t'(
        wb_dat_i[7:5] & dac_enable_pkg::reg_write_mask[7:5]);
    end
    if (req && hit && !wb_we_i) begin
      dat_next = {24'h00_0000, ctrl_reg,
                  dac_enable_pkg::unused_read};
    end
    en_next = decode_enables(ctrl_reg);
  end

  always_ff @(posedge core_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      ctrl_reg <= dac_enable_pkg::dac_control_t'(
        dac_enable_pkg::enables_reset);
      en_reg <= '0;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      en_reg <= en_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign conv_en_ch0 = en_reg.conv_en_ch0;
  assign conv_en_ch1 = en_reg.conv_en_ch1;
  assign analog_out_ch0 = en_reg.analog_out_ch0;
  assign analog_out_ch1 = en_reg.analog_out_ch1;

  property both_off_p;
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      (!ctrl_reg.ch0_output_enable && !ctrl_reg.ch1_output_enable)
      |=> (!conv_en_ch0 && !conv_en_ch1);
  endproperty
  all_disabled_a: assert property (both_off_p)
    else $error("converter on with both output enables clear");

  ch0_only_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      (ctrl_reg == 3'b010) |=> (conv_en_ch0 && !conv_en_ch1))
    else $error("channel 0 only mode wrong");

  ch1_only_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      (ctrl_reg == 3'b100) |=> (!conv_en_ch0 && conv_en_ch1))
    else $error("channel 1 only mode wrong");

  both_on_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      (ctrl_reg == 3'b110 || ctrl_reg == 3'b011 || ctrl_reg == 3'b101 ||
       ctrl_reg == 3'b111) |=> (conv_en_ch0 && conv_en_ch1))
    else $error("both channels should convert");

  ch0_pin_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      1'b1 |=> (analog_out_ch0 == $past(ctrl_reg.ch0_output_enable)) &&
               (!analog_out_ch0 || conv_en_ch0))
    else $error("channel 0 analog output mismatch");

  ch1_pin_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      1'b1 |=> (analog_out_ch1 == $past(ctrl_reg.ch1_output_enable)) &&
               (!analog_out_ch1 || conv_en_ch1))
    else $error("channel 1 analog output mismatch");

  sequence read_req_s;
    req && hit && !wb_we_i;
  endsequence
  low_bits_one_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      read_req_s |=> (wb_ack_o && wb_dat_o[4:0] == 5'h1F &&
                      wb_dat_o[31:8] == 24'h00_0000))
    else $error("read data of unused bits wrong");

  sequence write_req_s;
    req && hit && wb_we_i && wb_sel_i[0];
  endsequence

  sequence ignored_req_s;
    req && (!hit || !wb_we_i || !wb_sel_i[0]);
  endsequence

  write_take_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      write_req_s
      |=> (ctrl_reg == $past(wb_dat_i[7:5])) && wb_ack_o)
    else $error("write not stored in control bits");

  // only a write to the control address with byte lane 0 selected may move the enable bits
  write_ignored_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      ignored_req_s |=> $stable(ctrl_reg))
    else $error("control bits changed by an ignored access");

  read_ctrl_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      read_req_s |=> (wb_dat_o[7:5] == $past(ctrl_reg)))
    else $error("read data of enable bits wrong");

  // each request gets exactly one ack in the following cycle
  ack_follows_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      req |=> wb_ack_o)
    else $error("request not acknowledged");

  ack_pulse_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  idle_data_zero_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
    else $error("read data not zero outside ack");

  unmapped_read_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      (req && !hit && !wb_we_i) |=> (wb_dat_o == 32'h0000_0000))
    else $error("unmapped read returned data");

  // shared bit alone never starts a converter
  ch0_conv_cause_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      conv_en_ch0 |-> (analog_out_ch0 || analog_out_ch1))
    else $error("channel 0 converts with no output enable");

  ch1_conv_cause_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      conv_en_ch1 |-> (analog_out_ch0 || analog_out_ch1))
    else $error("channel 1 converts with no output enable");

  // a channel without its own enable converts only when both do
  borrowed_conv_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n_reg)
      ((conv_en_ch0 && !analog_out_ch0) || (conv_en_ch1 && !analog_out_ch1))
      |-> (conv_en_ch0 && conv_en_ch1))
    else $error("one channel converts on the other's enable alone");
endmodule // dac_enable_control
`default_nettype wire

/* File: verification/dac_channel_model.sv */
// partner model: one converter channel and its analog pin
`timescale 1ns/1ps
`default_nettype none
module dac_channel_model (
  input wire logic conv_en,
  input wire logic analog_en,
  output logic pin_driven
);
  // the pin carries a level only while conversion and output both run
  assign pin_driven = conv_en & analog_en;
endmodule // dac_channel_model
`default_nettype wire

/* File: verification/dac_enable_control_tb_top.sv */
// testbench: register access and enable decoding of the converter control
`timescale 1ns/1ps
`default_nettype none
module dac_enable_control_tb_top;
  logic core_clk = 0, arst_n = 0, we = 0, cyc = 0, stb = 0, ack;
  logic [23:0] adr = '0;
  logic [31:0] dat_w = '0, dat_r, rd;
  logic [3:0] sel = 4'h0;
  logic c0, c1, a0, a1, p0, p1;
  int errors = 0, samples_checked = 0, cycles = 0;
  localparam logic [23:0] reg_adr = {2'b00, dac_enable_pkg::dac_control_addr};
  dac_enable_control u_dac_enable_control (.core_clk(core_clk),
    .arst_n(arst_n), .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .conv_en_ch0(c0), .conv_en_ch1(c1),
    .analog_out_ch0(a0), .analog_out_ch1(a1));
  dac_channel_model u_ch0 (.conv_en(c0), .analog_en(a0), .pin_driven(p0));
  dac_channel_model u_ch1 (.conv_en(c1), .analog_en(a1), .pin_driven(p1));
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [23:0] a,
                    input logic [3:0] s, input logic [31:0] d);
    @(posedge core_clk);
    {cyc, stb, we, adr, sel, dat_w} <= {2'b11, w, a, s, d};
    do @(posedge core_clk); while (ack !== 1'b1);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic cmp_data(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED read data exp %h got %h", e, g);
    end
  endtask
  task automatic cmp_en(input logic [5:0] e, input logic [5:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED enables exp %b got %b", e, g);
    end
  endtask
  // b holds ch1 enable, ch0 enable, shared enable
  function automatic logic [5:0] exp_en(input logic [2:0] b);
    logic any;
    any = b[2] | b[1];
    return {b[1] | (any & b[0]), b[2] | (any & b[0]), b[1], b[2], b[1], b[2]};
  endfunction
  initial begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    cmp_en(6'h00, {c0, c1, a0, a1, p0, p1});
    wb(1'b0, reg_adr, 4'hF, 32'h0);
    cmp_data(32'h1F, rd);
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, reg_adr, 4'h1, {24'hFFFFFF, i[2:0], 5'h0A});
      wb(1'b0, reg_adr, 4'hF, 32'h0);
      cmp_data({24'h0, i[2:0], 5'h1F}, rd);
      cmp_en(exp_en(i[2:0]), {c0, c1, a0, a1, p0, p1});
    end
    // low byte lane off and a neighbouring address must both leave it alone
    wb(1'b1, reg_adr, 4'hE, 32'h0);
    wb(1'b1, reg_adr + 24'h4, 4'hF, 32'h0);
    wb(1'b0, reg_adr + 24'h4, 4'hF, 32'h0);
    cmp_data(32'h0, rd);
    wb(1'b0, reg_adr, 4'hF, 32'h0);
    cmp_data(32'hFF, rd);
    cmp_en(6'h3F, {c0, c1, a0, a1, p0, p1});
    tally_and_finish();
  end
endmodule // dac_enable_control_tb_top
`default_nettype wire
